//--- rus_pkg.sv
// Shared constants, types and register map of the reconfiguration sequencer
package rus_pkg;

    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PULSE_MIN_NS = 250;
    localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_PERIOD_NS = 100;
    localparam int OSC_DIV_CYC = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int USER_CLK_MAX_MHZ = 40;

    // ==========================================
    // Watchdog shape
    localparam int WD_WIDTH = 29;
    localparam int WD_PROG_BITS = 12;
    localparam logic [16:0] WD_LOW_FILL = 17'h00008;

    // ==========================================
    // Register byte offsets
    localparam logic [7:0] ADDR_UPDATE_LO = 8'h00;
    localparam logic [7:0] ADDR_UPDATE_HI = 8'h04;
    localparam logic [7:0] ADDR_CONTROL_LO = 8'h08;
    localparam logic [7:0] ADDR_CONTROL_HI = 8'h0c;
    localparam logic [7:0] ADDR_HIST_CUR = 8'h10;
    localparam logic [7:0] ADDR_HIST_PRI = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_WD_COUNT = 8'h1c;

    // ==========================================
    // Values
    localparam logic [38:0] CTL_RESET = 39'h00_0000_0000;
    localparam logic [30:0] HIST_RESET = 31'h0000_0000;
    localparam logic [31:0] CAPTURE_BAD_WORD = 32'h8000_0000;
    localparam logic [4:0] CAUSE_PIN_RESET = 5'h10;
    localparam logic [4:0] CAUSE_CRC = 5'h08;
    localparam logic [4:0] CAUSE_STATUS_PIN = 5'h04;
    localparam logic [4:0] CAUSE_WATCHDOG = 5'h02;
    localparam logic [4:0] CAUSE_CORE = 5'h01;

    // ==========================================
    // Types
    typedef enum logic [1:0] {
        RUS_ST_FACTORY = 2'h0,
        RUS_ST_CONFIG = 2'h1,
        RUS_ST_USER = 2'h2,
        RUS_ST_RELOAD = 2'h3
    } rus_state_t;

    typedef struct packed {
        logic rsv2;
        logic early_done_check_option;
        logic osc_int;
        logic watchdog_enable_bit;
        logic rsv1;
        logic [21:0] boot_page_field;
        logic [11:0] watchdog_start_field;
    } rus_ctl_t;

    typedef struct packed {
        logic [4:0] cause;
        logic [1:0] exit_state;
        logic [23:0] boot_addr;
    } rus_hist_t;

endpackage : rus_pkg

//--- rus_min_pulse.sv
// Qualifies a level input that must be held a least number of cycles
`timescale 1ns/1ps
module rus_min_pulse #(
    parameter int MIN_CYC = rus_pkg::PULSE_MIN_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic level,
    output logic fire
);

    localparam int CW = $clog2(MIN_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(MIN_CYC - 1);

    logic [CW-1:0] cnt_reg;

    // ==========================================
    // Hold counter, saturates so one level gives one pulse
    always_ff @(posedge clock) begin
        if (rst || !level) begin
            cnt_reg <= '0;
        end else if (cnt_reg <= LAST) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    // Glitches shorter than the minimum never fire
    always_ff @(posedge clock) begin
        if (rst) begin
            fire <= 1'b0;
        end else begin
            fire <= level && (cnt_reg == LAST);
        end
    end

    AST_PULSE_HELD: assert property (@(posedge clock) disable iff (rst)
        fire |-> $past(level) && $past(level, 2)) else $error("short pulse accepted");

endmodule : rus_min_pulse

//--- rus_watchdog.sv
// User watchdog down-counter with reload and expiry pulse
`timescale 1ns/1ps
module rus_watchdog #(
    parameter int WIDTH = rus_pkg::WD_WIDTH,
    parameter int PROG = rus_pkg::WD_PROG_BITS
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic run,
    input wire logic tick,
    input wire logic reload,
    input wire logic [PROG-1:0] start_field,
    output logic [WIDTH-1:0] count,
    output logic expired
);

    logic [WIDTH-1:0] load_val;

    assign load_val = {start_field, rus_pkg::WD_LOW_FILL};

    // ==========================================
    // Counter; held at start value while not running
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= '0;
            expired <= 1'b0;
        end else if (!run || reload) begin
            count <= load_val;
            expired <= 1'b0;
        end else if (tick && count != '0) begin
            count <= count - WIDTH'(1);
            expired <= (count == WIDTH'(1));
        end else begin
            expired <= 1'b0;
        end
    end

    AST_WD_RELOAD: assert property (@(posedge clock) disable iff (rst)
        run && reload |=> count == $past(load_val)) else $error("reload lost");
    AST_WD_EXPIRE: assert property (@(posedge clock) disable iff (rst)
        run && !reload && tick && count == WIDTH'(1) |=> expired && count == '0)
        else $error("expiry missed");
    AST_WD_STEP: assert property (@(posedge clock) disable iff (rst)
        run && !reload && tick && count > WIDTH'(1) |=> !expired && count == $past(count) - 1)
        else $error("bad decrement");

endmodule : rus_watchdog

//--- rus_sequencer.sv
// Reconfiguration sequencer: control/update, exit history, watchdog, APB slave
// Function
// - Keep exit records of the last two application images, for debug only.
// - Current-image record and prior-image record share one field layout.
// - Cause field one-hot: 30 pin reset, 29 CRC, 28 status, 27 watchdog, 26 core.
// - Simultaneous causes: only the highest bit is recorded.
// - Bits 25:24 hold master state when the image was left.
// - Bits 23:0 hold boot address of the exited image.
// - Reading history before any application image returns an improper-capture word.
// - Update and control share layout; update written by software only in factory.
// - Core trigger copies update into control, then reconfigures from it.
// - Pin reset, status, CRC, watchdog clear control; core trigger loads update.
// - Status is updated after the error, before factory load starts.
// - Watchdog is a 29-bit down-counter started from the control value.
// - Only the top 12 bits are programmable; fill 17'b1000 below.
// - Watchdog counts the internal 10 MHz oscillator or user clock.
// - Watchdog off in factory and during configuration; runs in user mode.
// - Expiry sets the watchdog cause flag and loads the factory image.
// - Watchdog runs only with enable bit 35 set.
// - Boot address is the 22-bit page field with two zero bits below.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module rus_sequencer (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic config_reset_pin,
    input wire logic config_error_pin,
    input wire logic crc_error,
    input wire logic config_done,
    input wire logic core_reconfig_trigger,
    input wire logic watchdog_reload_input,
    input wire logic user_clock_input,
    output rus_pkg::rus_ctl_t control_out,
    output logic [23:0] boot_address,
    output rus_pkg::rus_state_t master_state,
    output logic reconfig_start,
    output logic watchdog_timeout
);

    // ==========================================
    // Declarations
    rus_pkg::rus_state_t state_reg;
    rus_pkg::rus_state_t state_next;
    rus_pkg::rus_ctl_t update_reg;
    rus_pkg::rus_ctl_t control_reg;
    rus_pkg::rus_hist_t hist_cur_reg;
    rus_pkg::rus_hist_t hist_pri_reg;
    logic [38:0] upd_bits;
    logic [38:0] ctl_bits;
    logic [4:0] cause_raw;
    logic [4:0] cause_win;
    logic [4:0] last_cause_reg;
    logic ev;
    logic in_app;
    logic core_won;
    logic app_seen_reg;
    logic [23:0] boot_address_reg;
    logic reconfig_start_reg;
    logic [3:0] osc_cnt_reg;
    logic osc_tick_reg;
    logic uclk_d_reg;
    logic user_tick;
    logic wd_tick;
    logic wd_run;
    logic wd_expired;
    logic [28:0] wd_count;
    logic trig_fire;
    logic reload_fire;
    logic access;
    logic [31:0] rd_word;
    logic rd_err;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    assign upd_bits = update_reg;
    assign ctl_bits = control_reg;

    // ==========================================
    // Minimum-width qualifiers for the two strobes
    // trigger width check
    rus_min_pulse #(
        .MIN_CYC(rus_pkg::PULSE_MIN_CYC)
    ) u_trig_q (
        .clock(clock),
        .rst(rst),
        .level(core_reconfig_trigger),
        .fire(trig_fire)
    );

    rus_min_pulse #(
        .MIN_CYC(rus_pkg::PULSE_MIN_CYC)
    ) u_reload_q (
        .clock(clock),
        .rst(rst),
        .level(watchdog_reload_input),
        .fire(reload_fire)
    );

    // ==========================================
    // Watchdog tick sources
    // Oscillator stand-in: divider rounded up, so never faster than 10 MHz
    always_ff @(posedge clock) begin
        if (rst || osc_cnt_reg == 4'(rus_pkg::OSC_DIV_CYC - 1)) begin
            osc_cnt_reg <= 4'h0;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            osc_tick_reg <= 1'b0;
        end else begin
            osc_tick_reg <= (osc_cnt_reg == 4'(rus_pkg::OSC_DIV_CYC - 1));
        end
    end

    // User clock sampled as data; its 40 MHz limit keeps edges apart
    always_ff @(posedge clock) begin
        if (rst) begin
            uclk_d_reg <= 1'b0;
        end else begin
            uclk_d_reg <= user_clock_input;
        end
    end

    assign user_tick = user_clock_input && !uclk_d_reg;
    assign wd_tick = control_reg.osc_int ? osc_tick_reg : user_tick;

    // run only in user mode with enable set
    assign wd_run = (state_reg == rus_pkg::RUS_ST_USER) && control_reg.watchdog_enable_bit;

    rus_watchdog #(
        .WIDTH(rus_pkg::WD_WIDTH),
        .PROG(rus_pkg::WD_PROG_BITS)
    ) u_wd (
        .clock(clock),
        .rst(rst),
        .run(wd_run),
        .tick(wd_tick),
        .reload(reload_fire),
        .start_field(control_reg.watchdog_start_field),
        .count(wd_count),
        .expired(wd_expired)
    );

    // ==========================================
    // Cause collection and priority
    assign cause_raw = {config_reset_pin, crc_error, config_error_pin, wd_expired, trig_fire};

    always_comb begin
        casez (cause_raw)
            5'b1????: cause_win = rus_pkg::CAUSE_PIN_RESET;
            5'b01???: cause_win = rus_pkg::CAUSE_CRC;
            5'b001??: cause_win = rus_pkg::CAUSE_STATUS_PIN;
            5'b0001?: cause_win = rus_pkg::CAUSE_WATCHDOG;
            5'b00001: cause_win = rus_pkg::CAUSE_CORE;
            default: cause_win = 5'h00;
        endcase
    end

    // Causes during the one-cycle reload state are dropped
    assign ev = (|cause_raw) && (state_reg != rus_pkg::RUS_ST_RELOAD);
    assign core_won = (cause_win == rus_pkg::CAUSE_CORE);
    assign in_app = (state_reg == rus_pkg::RUS_ST_CONFIG) || (state_reg == rus_pkg::RUS_ST_USER);

    // ==========================================
    // Master state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rus_pkg::RUS_ST_FACTORY, rus_pkg::RUS_ST_USER: begin
                if (ev) begin
                    state_next = rus_pkg::RUS_ST_RELOAD;
                end
            end
            rus_pkg::RUS_ST_CONFIG: begin
                if (ev) begin
                    state_next = rus_pkg::RUS_ST_RELOAD;
                end else if (config_done) begin
                    state_next = rus_pkg::RUS_ST_USER;
                end
            end
            rus_pkg::RUS_ST_RELOAD: begin
                // core trigger boots the new page; others boot factory
                if (last_cause_reg == rus_pkg::CAUSE_CORE) begin
                    state_next = rus_pkg::RUS_ST_CONFIG;
                end else begin
                    state_next = rus_pkg::RUS_ST_FACTORY;
                end
            end
            default: state_next = rus_pkg::RUS_ST_FACTORY;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= rus_pkg::RUS_ST_FACTORY;
        end else begin
            state_reg <= state_next;
        end
    end

    // Reconfiguration starts one cycle after the status and control settle
    always_ff @(posedge clock) begin
        if (rst) begin
            reconfig_start_reg <= 1'b0;
        end else begin
            reconfig_start_reg <= (state_reg == rus_pkg::RUS_ST_RELOAD);
        end
    end

    // ==========================================
    // Control register, written only by the sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            control_reg <= rus_pkg::CTL_RESET;
        end else if (ev) begin
            control_reg <= core_won ? update_reg : rus_pkg::CTL_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            boot_address_reg <= 24'h00_0000;
        end else begin
            boot_address_reg <= {control_reg.boot_page_field, 2'h0};
        end
    end

    // ==========================================
    // Status: last cause, written at the event edge, before factory load
    // cause flag capture
    always_ff @(posedge clock) begin
        if (rst) begin
            last_cause_reg <= 5'h00;
        end else if (ev) begin
            last_cause_reg <= cause_win;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            app_seen_reg <= 1'b0;
        end else if (state_reg == rus_pkg::RUS_ST_CONFIG) begin
            app_seen_reg <= 1'b1;
        end
    end

    // ==========================================
    // Exit history; only leaving an application image is recorded
    // shift current into prior
    always_ff @(posedge clock) begin
        if (rst) begin
            hist_cur_reg <= rus_pkg::HIST_RESET;
            hist_pri_reg <= rus_pkg::HIST_RESET;
        end else if (ev && in_app) begin
            hist_pri_reg <= hist_cur_reg;
            hist_cur_reg <= {cause_win, state_reg, boot_address_reg};
        end
    end

    // ==========================================
    // APB slave: one wait state, answer in the second access cycle
    assign access = psel && penable;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            rus_pkg::ADDR_UPDATE_LO: begin
                rd_word = upd_bits[31:0];
                rd_err = pwrite && (state_reg != rus_pkg::RUS_ST_FACTORY);
            end
            rus_pkg::ADDR_UPDATE_HI: begin
                rd_word = {25'h000_0000, upd_bits[38:32]};
                rd_err = pwrite && (state_reg != rus_pkg::RUS_ST_FACTORY);
            end
            rus_pkg::ADDR_CONTROL_LO: begin
                rd_word = ctl_bits[31:0];
                rd_err = pwrite;
            end
            rus_pkg::ADDR_CONTROL_HI: begin
                rd_word = {25'h000_0000, ctl_bits[38:32]};
                rd_err = pwrite;
            end
            rus_pkg::ADDR_HIST_CUR: begin
                rd_word = app_seen_reg ? {1'b0, hist_cur_reg} : rus_pkg::CAPTURE_BAD_WORD;
                rd_err = pwrite;
            end
            rus_pkg::ADDR_HIST_PRI: begin
                rd_word = app_seen_reg ? {1'b0, hist_pri_reg} : rus_pkg::CAPTURE_BAD_WORD;
                rd_err = pwrite;
            end
            rus_pkg::ADDR_STATUS: begin
                rd_word = {state_reg, 23'h00_0000, app_seen_reg, wd_run, last_cause_reg};
                rd_err = pwrite;
            end
            rus_pkg::ADDR_WD_COUNT: begin
                rd_word = {3'h0, wd_count};
                rd_err = pwrite;
            end
            default: begin
                rd_word = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end

    // Handshake and read data, set in the first access cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (access && !pready_reg) begin
            pready_reg <= 1'b1;
            pslverr_reg <= rd_err;
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // update writes at the completing edge, factory only
    always_ff @(posedge clock) begin
        if (rst) begin
            update_reg <= rus_pkg::CTL_RESET;
        end else if (access && pready_reg && pwrite && !pslverr_reg
                     && state_reg == rus_pkg::RUS_ST_FACTORY) begin
            if (paddr == rus_pkg::ADDR_UPDATE_LO) begin
                update_reg <= {upd_bits[38:32], pwdata};
            end else if (paddr == rus_pkg::ADDR_UPDATE_HI) begin
                update_reg <= {pwdata[6:0], upd_bits[31:0]};
            end
        end
    end

    // ==========================================
    // Outputs, all from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign control_out = control_reg;
    assign boot_address = boot_address_reg;
    assign master_state = state_reg;
    assign reconfig_start = reconfig_start_reg;
    assign watchdog_timeout = wd_expired;

    // ==========================================
    // Checks
    AST_CAUSE_ONEHOT: assert property (@(posedge clock) disable iff (rst)
        $onehot0(hist_cur_reg.cause) && $onehot0(last_cause_reg))
        else $error("cause not one-hot");

    AST_PIN_PRIORITY: assert property (@(posedge clock) disable iff (rst)
        config_reset_pin && state_reg != rus_pkg::RUS_ST_RELOAD
        |=> last_cause_reg == rus_pkg::CAUSE_PIN_RESET) else $error("priority lost");

    AST_CTL_CLEAR: assert property (@(posedge clock) disable iff (rst)
        ev && !core_won |=> control_reg == rus_pkg::CTL_RESET)
        else $error("control not cleared");

    AST_CTL_COPY: assert property (@(posedge clock) disable iff (rst)
        ev && core_won |=> control_reg == $past(update_reg) ##1
        state_reg == rus_pkg::RUS_ST_CONFIG) else $error("trigger copy failed");

    AST_HIST_SHIFT: assert property (@(posedge clock) disable iff (rst)
        ev && in_app |=> hist_pri_reg == $past(hist_cur_reg)
        && hist_cur_reg.boot_addr == $past(boot_address_reg)
        && hist_cur_reg.exit_state == $past(state_reg)) else $error("history wrong");

    AST_UPD_LOCK: assert property (@(posedge clock) disable iff (rst)
        state_reg != rus_pkg::RUS_ST_FACTORY |=> $stable(update_reg))
        else $error("update written outside factory");

    AST_WD_OFF: assert property (@(posedge clock) disable iff (rst)
        state_reg != rus_pkg::RUS_ST_USER |=> !wd_expired) else $error("watchdog ran");

    AST_WD_FACTORY: assert property (@(posedge clock) disable iff (rst)
        wd_expired && !config_reset_pin && !crc_error && !config_error_pin
        && state_reg == rus_pkg::RUS_ST_USER
        |=> last_cause_reg == rus_pkg::CAUSE_WATCHDOG ##1
        state_reg == rus_pkg::RUS_ST_FACTORY) else $error("timeout path wrong");

    AST_CAPTURE_BAD: assert property (@(posedge clock) disable iff (rst)
        access && !pready_reg && !pwrite && !app_seen_reg && paddr == rus_pkg::ADDR_HIST_CUR
        |=> prdata == rus_pkg::CAPTURE_BAD_WORD) else $error("capture flag missing");

endmodule : rus_sequencer

//--- rus_user_model.sv
// User-logic model that drives trigger, reload and user clock
`timescale 1ns/1ps
module rus_user_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic trig_req,
    input wire logic reload_req,
    output logic core_reconfig_trigger,
    output logic watchdog_reload_input,
    output logic user_clock_input
);
    // Two spare cycles so the qualifier never sees a short strobe
    localparam int HOLD = rus_pkg::PULSE_MIN_CYC + 2;
    int trig_cnt;
    int rld_cnt;
    logic [1:0] div_reg;
    // ==========================================
    // Strobes
    // trigger hold time
    always_ff @(posedge clock) begin
        if (rst) trig_cnt <= 0;
        else if (trig_req) trig_cnt <= HOLD;
        else if (trig_cnt != 0) trig_cnt <= trig_cnt - 1;
    end
    always_ff @(posedge clock) begin
        if (rst) rld_cnt <= 0;
        else if (reload_req) rld_cnt <= HOLD;
        else if (rld_cnt != 0) rld_cnt <= rld_cnt - 1;
    end
    assign core_reconfig_trigger = (trig_cnt != 0);
    assign watchdog_reload_input = (rld_cnt != 0);
    // User clock a quarter of the system clock, 31.25 MHz, under the 40 MHz ceiling
    always_ff @(posedge clock) begin
        if (rst) div_reg <= 2'h0;
        else div_reg <= div_reg + 2'h1;
    end
    assign user_clock_input = div_reg[1];
endmodule : rus_user_model

//--- rus_sequencer_test.sv
// Self-checking bench for the reconfiguration sequencer
`timescale 1ns/1ps
module rus_sequencer_test;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, rs, wto, tr, rl;
    logic pin, sts, crc, done, trig, rld, uclk, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, wd_word;
    logic [23:0] boot;
    rus_pkg::rus_ctl_t ctl;
    rus_pkg::rus_state_t st;
    int error_cnt = 0, num_checks = 0, to_cnt = 0, rs_cnt = 0, n, k;
    rus_sequencer dut (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .config_reset_pin(pin),
        .config_error_pin(sts), .crc_error(crc), .config_done(done),
        .core_reconfig_trigger(trig), .watchdog_reload_input(rld),
        .user_clock_input(uclk), .control_out(ctl), .boot_address(boot),
        .master_state(st), .reconfig_start(rs), .watchdog_timeout(wto));
    rus_user_model far (.clock(clock), .rst(rst), .trig_req(tr), .reload_req(rl),
        .core_reconfig_trigger(trig), .watchdog_reload_input(rld),
        .user_clock_input(uclk));
    // ==========================================
    // Helpers
    initial begin
        clock = 0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) if (wto === 1'b1) to_cnt++;
    always @(posedge clock) if (rs === 1'b1) rs_cnt++;
    task complete_run;
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; pready, prdata and pslverr are taken at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock) penable <= 1;
        n = 0;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin error_cnt++; complete_run(); end
        q = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        // Idle cycle, so a following call never re-drives psel in this step
        @(posedge clock);
    endtask : apb
    task wait_state(input rus_pkg::rus_state_t s);
        n = 0;
        do begin @(negedge clock); n++; end while (st !== s && n < 500);
        if (n >= 500) begin error_cnt++; complete_run(); end
        @(posedge clock);
    endtask : wait_state
    // ==========================================
    // Scenarios
    initial begin
        {psel, penable, pwrite, pin, sts, crc, done, tr, rl} = '0;
        paddr = 8'h00; pwdata = 32'h0; rst = 1;
        repeat (12) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        apb(0, rus_pkg::ADDR_HIST_CUR, 0); chk(q, 32'h8000_0000);
        apb(1, rus_pkg::ADDR_UPDATE_LO, 32'h1234_5000); chk({31'h0, er}, 32'h0);
        apb(1, rus_pkg::ADDR_UPDATE_HI, 32'h0000_0038);
        apb(0, rus_pkg::ADDR_UPDATE_LO, 0); chk(q, 32'h1234_5000);
        apb(1, rus_pkg::ADDR_CONTROL_LO, 32'h1); chk({31'h0, er}, 32'h1);
        apb(0, 8'h20, 0); chk({31'h0, er}, 32'h1);
        tr <= 1; @(posedge clock) tr <= 0;
        wait_state(rus_pkg::RUS_ST_CONFIG);
        chk({25'h0, ctl[38:32]}, 32'h38); chk(ctl[31:0], 32'h1234_5000);
        chk({8'h0, boot}, {8'h0, 22'h01_2345, 2'h0});
        apb(1, rus_pkg::ADDR_UPDATE_LO, 32'h0); chk({31'h0, er}, 32'h1);
        repeat (300) @(posedge clock);
        chk(to_cnt, 0);
        done <= 1;
        wait_state(rus_pkg::RUS_ST_USER);
        repeat (3) begin
            rl <= 1; @(posedge clock) rl <= 0;
            repeat (60) @(posedge clock);
        end
        chk(to_cnt, 0);
        rl <= 1; @(posedge clock) rl <= 0;
        n = 0;
        do begin @(negedge clock); n++; end while (to_cnt == 0 && n < 400);
        chk({31'h0, n > 110 && n < 175}, 32'h1);
        wait_state(rus_pkg::RUS_ST_FACTORY);
        done <= 0;
        chk(ctl[31:0], 0); chk({25'h0, ctl[38:32]}, 0);
        wd_word = {1'b0, 5'h02, 2'h2, 22'h01_2345, 2'h0};
        apb(0, rus_pkg::ADDR_HIST_CUR, 0); chk(q, wd_word);
        apb(0, rus_pkg::ADDR_STATUS, 0); chk({27'h0, q[4:0]}, 32'h2);
        tr <= 1; @(posedge clock) tr <= 0;
        wait_state(rus_pkg::RUS_ST_CONFIG);
        pin <= 1; crc <= 1;
        @(posedge clock) begin pin <= 0; crc <= 0; end
        wait_state(rus_pkg::RUS_ST_FACTORY);
        chk(ctl[31:0], 0);
        apb(0, rus_pkg::ADDR_HIST_CUR, 0);
        chk(q, {1'b0, 5'h10, 2'h1, 22'h01_2345, 2'h0});
        apb(0, rus_pkg::ADDR_HIST_PRI, 0); chk(q, wd_word);
        // Status-pin error while configuring the application
        tr <= 1; @(posedge clock) tr <= 0;
        wait_state(rus_pkg::RUS_ST_CONFIG);
        sts <= 1; @(posedge clock) sts <= 0;
        wait_state(rus_pkg::RUS_ST_FACTORY);
        chk(ctl[31:0], 0);
        apb(0, rus_pkg::ADDR_HIST_CUR, 0);
        chk(q, {1'b0, 5'h04, 2'h1, 22'h01_2345, 2'h0});
        apb(0, rus_pkg::ADDR_HIST_PRI, 0);
        chk(q, {1'b0, 5'h10, 2'h1, 22'h01_2345, 2'h0});
        // Watchdog on the user clock: about three times faster than the oscillator
        apb(1, rus_pkg::ADDR_UPDATE_HI, 32'h0000_0028);
        tr <= 1; @(posedge clock) tr <= 0;
        wait_state(rus_pkg::RUS_ST_CONFIG);
        k = to_cnt;
        done <= 1;
        n = 0;
        do begin @(negedge clock); n++; end while (to_cnt == k && n < 400);
        chk({31'h0, n > 25 && n < 60}, 32'h1);
        wait_state(rus_pkg::RUS_ST_FACTORY);
        apb(0, rus_pkg::ADDR_HIST_CUR, 0); chk(q, wd_word);
        // Enable bit clear: no timeout in user mode
        apb(1, rus_pkg::ADDR_UPDATE_HI, 32'h0000_0030);
        tr <= 1; @(posedge clock) tr <= 0;
        wait_state(rus_pkg::RUS_ST_USER);
        k = to_cnt;
        repeat (300) @(posedge clock);
        chk(to_cnt - k, 0);
        chk(rs_cnt, 9);
        complete_run();
    end
endmodule : rus_sequencer_test
